// [design/flash_status_protect.sv]
// status register and write protection of a serial flash
// How it works
// - busy flag set during status write, program, erase
// - write-enable latch readable as status bit 1
// - block-protect bits, three or four by variant
// - write-disable plus protect pin low locks bits
// - host sends write enable; device sets latch
// - latch clears at reset and command completion
// - protected region readable but never altered
// - 256K-sector codes select top 1..32 sectors or all
// - 64K-sector codes select top 2..128 sectors or all
// - modifying commands need whole bytes of clocks
// - protect pin low blocks block-protect changes only with write-disable set
`timescale 1ns/10ps
`include "flash_protect_defs.svh"

module flash_status_protect
    import flash_protect_pkg::*;
#(
    parameter bit SECTOR_64K = 1'b0
)
(
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_clock_en,
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic i_si,
    input wire logic i_write_protect_n,
    input wire logic i_op_done,
    output logic o_so,
    output logic o_so_oe,
    output logic o_busy,
    output logic o_op_start,
    output logic [1:0] o_op_kind,
    output logic [23:0] o_op_addr,
    output logic [7:0] o_status
);

    core_state_t q;
    core_state_t d;
    logic [7:0] rx_byte;
    logic rx_tog;
    logic rx_partial;
    logic byte_ev;
    logic frame_start;
    logic frame_end;
    logic hw_protected;
    logic addr_locked;
    logic region_used;
    logic [2:0] cnt_next;

    // ----------------------------------------------------------------
    // protected region start address for a block-protect code
    // ----------------------------------------------------------------
    function automatic logic [24:0] prot_start(input logic [3:0] bp);
        logic [24:0] start;
        start = `ARRAY_TOP;
        if (SECTOR_64K)
        begin
            if (bp[3])
                start = `ARRAY_BOTTOM;
            else if (bp[2:0] != 3'h0)
                start = `ARRAY_TOP - (`SECTOR_64K << bp[2:0]);
        end
        else
        begin
            if (bp[2:0] == 3'h7)
                start = `ARRAY_BOTTOM;
            else if (bp[2:0] != 3'h0)
                start = `ARRAY_TOP - (`SECTOR_256K << (bp[2:0] - 3'h1));
        end
        return start;
    endfunction

    // ----------------------------------------------------------------
    // serial clock domain
    // ----------------------------------------------------------------
    flash_serial_link u_link (
        .i_rst_n(i_rst_n),
        .i_sck(i_sck),
        .i_cs_n(i_cs_n),
        .i_si(i_si),
        .i_status(q.status),
        .o_byte(rx_byte),
        .o_byte_tog(rx_tog),
        .o_partial(rx_partial),
        .o_so(o_so),
        .o_so_oe(o_so_oe)
    );

    // ----------------------------------------------------------------
    // command handling in the system clock domain
    // ----------------------------------------------------------------
    // frame end is taken one stage after the last byte can land, so a
    // byte toggle and the select edge are never seen out of order
    assign byte_ev = (q.tg_s2 != q.tg_s3) && !q.cs_s3;
    assign frame_start = q.cs_s3 && !q.cs_s2;
    assign frame_end = q.cs_s3 && !q.cs_s4;
    assign hw_protected = q.status_write_disable && !q.wp_s2;
    assign addr_locked = ({1'b0, q.addr} >= prot_start(q.bp));
    assign region_used = (prot_start(q.bp) != `ARRAY_TOP);
    assign cnt_next = (q.cnt == `LEN_SATURATE) ? q.cnt : q.cnt + 3'h1;

    always_comb
    begin
        d = q;
        d.cs_s1 = i_cs_n;
        d.cs_s2 = q.cs_s1;
        d.cs_s3 = q.cs_s2;
        d.cs_s4 = q.cs_s3;
        d.tg_s1 = rx_tog;
        d.tg_s2 = q.tg_s1;
        d.tg_s3 = q.tg_s2;
        d.wp_s1 = i_write_protect_n;
        d.wp_s2 = q.wp_s1;
        d.op_start = 1'b0;

        if (frame_start)
        begin
            d.state = ST_OPCODE;
            d.cnt = 3'h0;
        end

        if (byte_ev)
        begin
            d.cnt = cnt_next;
            case (q.state)
                ST_OPCODE:
                begin
                    d.opcode = rx_byte;
                    if (rx_byte == `OPC_PAGE_PROGRAM ||
                        rx_byte == `OPC_SECTOR_ERASE)
                        d.state = ST_ADDR;
                    else if (rx_byte == `OPC_STATUS_WRITE)
                        d.state = ST_DATA;
                    else
                        d.state = ST_SKIP;
                end
                ST_ADDR:
                begin
                    d.addr = {q.addr[15:0], rx_byte};
                    if (q.cnt == `LEN_ADDR_LAST)
                        d.state = ST_SKIP;
                end
                ST_DATA:
                begin
                    d.wdata = rx_byte;
                    d.state = ST_SKIP;
                end
                ST_SKIP:
                begin
                    d.state = ST_SKIP;
                end
                default:
                begin
                    d.state = ST_SKIP;
                end
            endcase
        end

        // commands other than status read arriving while busy are dropped; the host learns of
        // completion only by polling the status byte
        if (frame_end && !rx_partial && !q.busy)
        begin
            if (q.opcode == `OPC_WRITE_ENABLE && q.cnt == `LEN_OPCODE_ONLY)
                d.write_enable_latch = 1'b1;
            else if (q.opcode == `OPC_WRITE_DISABLE &&
                     q.cnt == `LEN_OPCODE_ONLY)
                d.write_enable_latch = 1'b0;
            else if (q.opcode == `OPC_STATUS_WRITE && q.write_enable_latch &&
                     q.cnt >= `LEN_STATUS_WRITE && !hw_protected)
            begin
                d.busy = 1'b1;
                d.srw_cnt = 10'(`SRW_CYCLES);
            end
            else if (q.opcode == `OPC_PAGE_PROGRAM && q.write_enable_latch &&
                     q.cnt >= `LEN_PAGE_PROGRAM && !addr_locked)
            begin
                d.busy = 1'b1;
                d.eng = 1'b1;
                d.op_start = 1'b1;
                d.op_kind = OP_PROGRAM;
                d.op_addr = q.addr;
            end
            else if (q.opcode == `OPC_SECTOR_ERASE && q.write_enable_latch &&
                     q.cnt == `LEN_SECTOR_ERASE && !addr_locked)
            begin
                d.busy = 1'b1;
                d.eng = 1'b1;
                d.op_start = 1'b1;
                d.op_kind = OP_SECTOR;
                d.op_addr = q.addr;
            end
            else if (q.opcode == `OPC_BULK_ERASE && q.write_enable_latch &&
                     q.cnt == `LEN_OPCODE_ONLY && !region_used)
            begin
                d.busy = 1'b1;
                d.eng = 1'b1;
                d.op_start = 1'b1;
                d.op_kind = OP_BULK;
                d.op_addr = 24'h000000;
            end
        end

        // completion of the running operation
        if (q.busy && q.eng && i_op_done)
        begin
            d.busy = 1'b0;
            d.eng = 1'b0;
            d.write_enable_latch = 1'b0;
        end
        else if (q.busy && !q.eng)
        begin
            d.srw_cnt = q.srw_cnt - `SRW_ONE;
            if (q.srw_cnt == `SRW_ONE)
            begin
                // new non-volatile bits take effect only once written
                d.busy = 1'b0;
                d.write_enable_latch = 1'b0;
                d.status_write_disable = q.wdata[`ST_STATUS_WRITE_DISABLE];
                if (SECTOR_64K)
                    d.bp = q.wdata[`ST_BP_HI:`ST_BP_LO];
                else
                    d.bp = {1'b0, q.wdata[`ST_BP256_HI:`ST_BP_LO]};
            end
        end

        d.status = 8'h00;
        d.status[`ST_BUSY] = d.busy;
        d.status[`ST_WEL] = d.write_enable_latch;
        d.status[`ST_BP_HI:`ST_BP_LO] = d.bp;
        d.status[`ST_STATUS_WRITE_DISABLE] = d.status_write_disable;
    end

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            q <= '0;
            q.cs_s1 <= 1'b1;
            q.cs_s2 <= 1'b1;
            q.cs_s3 <= 1'b1;
            q.cs_s4 <= 1'b1;
            q.wp_s1 <= 1'b1;
            q.wp_s2 <= 1'b1;
            q.state <= ST_SKIP;
            q.write_enable_latch <= 1'b0;
            q.bp <= `NV_BP_RESET;
            q.status_write_disable <= `NV_STATUS_WRITE_DISABLE_RESET;
            q.op_kind <= OP_NONE;
        end
        else if (i_clock_en)
            q <= d;
    end

    assign o_busy = q.busy;
    assign o_op_start = q.op_start;
    assign o_op_kind = q.op_kind;
    assign o_op_addr = q.op_addr;
    assign o_status = q.status;

endmodule

// [design/flash_protect_defs.svh]
// constants for the status and write-protection block
`ifndef FLASH_PROTECT_DEFS_SVH
`define FLASH_PROTECT_DEFS_SVH

// ----------------------------------------------------------------
// command opcodes
// ----------------------------------------------------------------
`define OPC_WRITE_ENABLE 8'h06
`define OPC_WRITE_DISABLE 8'h04
`define OPC_READ_STATUS 8'h05
`define OPC_STATUS_WRITE 8'h01
`define OPC_PAGE_PROGRAM 8'h02
`define OPC_SECTOR_ERASE 8'hd8
`define OPC_BULK_ERASE 8'hc7

// ----------------------------------------------------------------
// status byte layout and reset values
// ----------------------------------------------------------------
`define ST_BUSY 0
`define ST_WEL 1
`define ST_BP_LO 2
`define ST_BP_HI 5
`define ST_BP256_HI 4
`define ST_STATUS_WRITE_DISABLE 7
`define NV_BP_RESET 4'h0
`define NV_STATUS_WRITE_DISABLE_RESET 1'b0

// ----------------------------------------------------------------
// frame lengths in bytes (byte count saturates at 7)
// ----------------------------------------------------------------
`define LEN_OPCODE_ONLY 3'h1
`define LEN_STATUS_WRITE 3'h2
`define LEN_ADDR_LAST 3'h3
`define LEN_SECTOR_ERASE 3'h4
`define LEN_PAGE_PROGRAM 3'h5
`define LEN_SATURATE 3'h7
`define BIT_LAST 3'h7

// ----------------------------------------------------------------
// protected-region arithmetic, 25 bits so the array top fits
// ----------------------------------------------------------------
`define ARRAY_TOP 25'h1000000
`define SECTOR_256K 25'h0040000
`define SECTOR_64K 25'h0010000
`define ARRAY_BOTTOM 25'h0000000

// ----------------------------------------------------------------
// status write duration
// ----------------------------------------------------------------
`define CLOCK_MHZ 100
`define SRW_TIME_NS 5000
`define SRW_CYCLES (((`SRW_TIME_NS * `CLOCK_MHZ) + 999) / 1000)
`define SRW_ONE 10'h001

`endif

// [design/flash_protect_pkg.sv]
// types shared by the status and write-protection block
package flash_protect_pkg;

    typedef enum logic [3:0] {
        ST_OPCODE = 4'b0001,
        ST_ADDR = 4'b0010,
        ST_DATA = 4'b0100,
        ST_SKIP = 4'b1000
    } frame_state_t;

    typedef enum logic [1:0] {
        OP_NONE = 2'h0,
        OP_PROGRAM = 2'h1,
        OP_SECTOR = 2'h2,
        OP_BULK = 2'h3
    } op_kind_t;

    typedef struct packed {
        logic [2:0] bit_cnt;
        logic [6:0] shreg;
        logic [7:0] rx_byte;
        logic tog;
        logic partial;
        logic first;
        logic reading;
        logic [7:0] st_s1;
        logic [7:0] st_s2;
        logic [7:0] tx;
    } link_state_t;

    typedef struct packed {
        logic cs_s1;
        logic cs_s2;
        logic cs_s3;
        logic cs_s4;
        logic tg_s1;
        logic tg_s2;
        logic tg_s3;
        logic wp_s1;
        logic wp_s2;
        frame_state_t state;
        logic [7:0] opcode;
        logic [23:0] addr;
        logic [2:0] cnt;
        logic [7:0] wdata;
        logic write_enable_latch;
        logic busy;
        logic eng;
        logic [9:0] srw_cnt;
        logic [3:0] bp;
        logic status_write_disable;
        logic op_start;
        op_kind_t op_kind;
        logic [23:0] op_addr;
        logic [7:0] status;
    } core_state_t;

endpackage

// [design/flash_serial_link.sv]
// serial-clock domain: byte receiver and status shifter
`timescale 1ns/10ps
`include "flash_protect_defs.svh"

module flash_serial_link
    import flash_protect_pkg::*;
(
    input wire logic i_rst_n,
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic i_si,
    input wire logic [7:0] i_status,
    output logic [7:0] o_byte,
    output logic o_byte_tog,
    output logic o_partial,
    output logic o_so,
    output logic o_so_oe
);

    link_state_t q;
    link_state_t d;
    logic fresh_q;
    logic so_q;
    logic oe_q;
    logic [2:0] cnt;

    // ----------------------------------------------------------------
    // frame start marker
    // ----------------------------------------------------------------
    // the serial clock stands still between frames, so the select pin
    // itself marks a new frame instead of a clocked edge detector
    always_ff @(posedge i_sck or posedge i_cs_n or negedge i_rst_n)
    begin
        if (!i_rst_n || i_cs_n)
            fresh_q <= 1'b1;
        else
            fresh_q <= 1'b0;
    end

    // ----------------------------------------------------------------
    // receive on the rising edge
    // ----------------------------------------------------------------
    always_comb
    begin
        d = q;
        d.st_s1 = i_status;
        d.st_s2 = q.st_s1;
        cnt = fresh_q ? 3'h0 : q.bit_cnt;
        d.first = fresh_q ? 1'b1 : q.first;
        d.reading = fresh_q ? 1'b0 : q.reading;
        d.bit_cnt = cnt + 3'h1;
        d.partial = (cnt != `BIT_LAST);
        d.shreg = {q.shreg[5:0], i_si};
        if (cnt == `BIT_LAST)
        begin
            d.rx_byte = {q.shreg, i_si};
            d.tog = ~q.tog;
            d.first = 1'b0;
            d.tx = q.st_s2;
            // only the opcode byte of a frame may turn the output on
            if ((fresh_q || q.first) &&
                ({q.shreg, i_si} == `OPC_READ_STATUS))
                d.reading = 1'b1;
        end
    end

    always_ff @(posedge i_sck or negedge i_rst_n)
    begin
        if (!i_rst_n)
            q <= '0;
        else
            q <= d;
    end

    // ----------------------------------------------------------------
    // transmit on the falling edge, msb first, status repeats per byte
    // ----------------------------------------------------------------
    always_ff @(negedge i_sck or posedge i_cs_n or negedge i_rst_n)
    begin
        if (!i_rst_n || i_cs_n)
        begin
            so_q <= 1'b0;
            oe_q <= 1'b0;
        end
        else
        begin
            so_q <= q.tx[~q.bit_cnt];
            oe_q <= q.reading;
        end
    end

    assign o_byte = q.rx_byte;
    assign o_byte_tog = q.tog;
    assign o_partial = q.partial;
    assign o_so = so_q;
    assign o_so_oe = oe_q;

endmodule

// [verif/flash_protect_assertions.sv]
// assertions for the status and write-protection block
`timescale 1ns/10ps
module flash_protect_assertions
#(
    parameter bit SECTOR_64K = 1'b0
)
(
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_cs_n,
    input wire logic i_write_protect_n,
    input wire logic o_so_oe,
    input wire logic o_busy,
    input wire logic o_op_start,
    input wire logic [1:0] o_op_kind,
    input wire logic [23:0] o_op_addr,
    input wire logic [7:0] o_status
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);

    a_busy_mirror: assert property (o_status[0] == o_busy)
        else $error("busy bit differs from busy output");
    a_start_busy: assert property (o_op_start |=> o_busy)
        else $error("engine started without busy");
    a_start_latch: assert property (o_op_start |-> o_status[1])
        else $error("engine started with latch clear");
    a_start_pulse: assert property (o_op_start |=> !o_op_start)
        else $error("start pulse longer than one cycle");
    a_rise_latch: assert property ($rose(o_busy) |-> o_status[1])
        else $error("busy rose with latch clear");
    a_fall_clear: assert property ($fell(o_busy) |-> ##[0:1] !o_status[1])
        else $error("latch still set after completion");
    a_bulk_free: assert property (o_op_start && o_op_kind == 2'h3
        |-> o_status[5:2] == 4'h0 && o_op_addr == 24'h0)
        else $error("bulk erase started with region protected");
    // the pin reaches the lock through two synchronizer stages, so wait
    a_hpm_lock: assert property ((o_status[7] && !i_write_protect_n)[*8]
        |=> $stable(o_status[7:2]))
        else $error("protect bits changed in hardware protected mode");
    a_bp_width: assert property (!o_status[6] && (SECTOR_64K || !o_status[5]))
        else $error("unused status bit set");
    a_so_idle: assert property (i_cs_n |-> !o_so_oe)
        else $error("output driven while deselected");
endmodule

bind flash_status_protect flash_protect_assertions
#(
    .SECTOR_64K(SECTOR_64K)
)
chk
(
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_cs_n(i_cs_n),
    .i_write_protect_n(i_write_protect_n),
    .o_so_oe(o_so_oe),
    .o_busy(o_busy),
    .o_op_start(o_op_start),
    .o_op_kind(o_op_kind),
    .o_op_addr(o_op_addr),
    .o_status(o_status)
);

// [verif/flash_host.sv]
// serial master model that stands on the host side of the link
`timescale 1ns/10ps
module flash_host
(
    input wire logic i_so,
    input wire logic i_so_oe,
    output logic o_sck,
    output logic o_cs_n,
    output logic o_si
);
    logic [7:0] rd_q;
    event got;
    initial
    begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
        o_si = 1'b0;
    end
    // mode 0, 30 ns period; sck stands still between frames
    task automatic frame(input logic [39:0] d, input int n);
        o_cs_n = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            o_si = d[39 - i];
            #15;
            o_sck = 1'b1;
            // unknown when not driven, so a silent output never matches
            if (i >= 8 && i < 16)
                rd_q = {rd_q[6:0], i_so_oe ? i_so : 1'bx};
            #15;
            o_sck = 1'b0;
        end
        #15;
        o_cs_n = 1'b1;
        o_si = ~o_si;
        if (n == 16 && d[39:32] == 8'h05)
            ->got;
        #100;
    endtask
endmodule

// [verif/flash_status_protect_tb.sv]
// self-checking bench for the status and write-protection block
`timescale 1ns/10ps
`include "flash_protect_defs.svh"
module flash_status_protect_tb;
    logic i_clock = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_write_protect_n = 1'b1;
    logic i_op_done = 1'b0;
    logic sck, cs_n, si, so, so_oe, busy, op_start;
    logic [1:0] op_kind;
    logic [23:0] op_addr;
    logic [7:0] status;
    logic [25:0] exp_op[$];
    logic [7:0] exp_st[$];
    logic [31:0] seed = 32'h0000000b;
    logic [31:0] r;
    logic [24:0] b;
    int mismatches = 0;
    int check_count = 0;
    int cyc = 0;
    logic [7:0] e_st;
    logic op64, done64;
    logic [1:0] kind64;
    logic [23:0] addr64;
    logic [7:0] st64;
    logic [25:0] exp_op64[$];

    always #5 i_clock = ~i_clock;

    flash_status_protect #(.SECTOR_64K(1'b0)) dut (.i_clock(i_clock),
        .i_rst_n(i_rst_n), .i_clock_en(1'b1), .i_sck(sck), .i_cs_n(cs_n),
        .i_si(si), .i_write_protect_n(i_write_protect_n),
        .i_op_done(i_op_done), .o_so(so), .o_so_oe(so_oe), .o_busy(busy),
        .o_op_start(op_start), .o_op_kind(op_kind), .o_op_addr(op_addr),
        .o_status(status));

    flash_host host (.i_so(so), .i_so_oe(so_oe), .o_sck(sck),
        .o_cs_n(cs_n), .o_si(si));

    // second variant listens to the same link; its engine answers one cycle after each start
    flash_status_protect #(.SECTOR_64K(1'b1)) dut64 (.i_clock(i_clock),
        .i_rst_n(i_rst_n), .i_clock_en(1'b1), .i_sck(sck), .i_cs_n(cs_n),
        .i_si(si), .i_write_protect_n(i_write_protect_n),
        .i_op_done(done64), .o_so(), .o_so_oe(), .o_busy(),
        .o_op_start(op64), .o_op_kind(kind64), .o_op_addr(addr64),
        .o_status(st64));

    function automatic logic [31:0] xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic bit prot(input logic [2:0] c, input logic [23:0] a);
        return c == 3'h7 || (c != 3'h0 &&
            {1'b0, a} >= 25'h1000000 - (25'h0040000 << (c - 3'h1)));
    endfunction

    function automatic bit prot64(input logic [3:0] c, input logic [23:0] a);
        return c[3] || (c != 4'h0 &&
            {1'b0, a} >= 25'h1000000 - (25'h0010000 << c[2:0]));
    endfunction

    task automatic chk_st(input logic [7:0] e, input logic [7:0] s);
        check_count++;
        if (s !== e)
        begin
            mismatches++;
            $display("BAD status exp %h got %h", e, s);
        end
    endtask

    task automatic chk_op(input logic [25:0] e, input logic [25:0] s);
        check_count++;
        if (s !== e)
        begin
            mismatches++;
            $display("BAD operation exp %h got %h", e, s);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic op(input logic [7:0] c, input logic [7:0] d);
        host.frame({c, d, 24'h0}, (c == `OPC_STATUS_WRITE) ? 16 : 8);
    endtask

    task automatic rd(input logic [7:0] e);
        exp_st.push_back(e);
        host.frame({`OPC_READ_STATUS, 32'h0}, 16);
    endtask

    task automatic poll();
        for (int k = 0; k < 40; k++)
        begin
            host.frame({`OPC_READ_STATUS, 32'h0}, 17);
            if (host.rd_q[0] === 1'b0)
                break;
        end
    endtask

    // one modifying command after a write enable, then the status it leaves
    task automatic attempt(input logic [7:0] c, input logic [23:0] a,
        input int n, input logic [3:0] bp, input bit ok);
        logic [1:0] k;
        k = (c == `OPC_PAGE_PROGRAM) ? 2'h1 :
            (c == `OPC_SECTOR_ERASE) ? 2'h2 : 2'h3;
        r = xorshift();
        op(`OPC_WRITE_ENABLE, 8'h00);
        if (ok)
            exp_op.push_back({k, (k == 2'h3) ? 24'h0 : a});
        if ((k == 2'h3) ? (bp == 4'h0) : !prot64(bp, a))
            exp_op64.push_back({k, (k == 2'h3) ? 24'h0 : a});
        host.frame({c, a, r[7:0]}, n);
        poll();
        rd({3'h0, bp[2:0], ~ok, 1'b0});
        op(`OPC_WRITE_DISABLE, 8'h00);
    endtask

    always @(host.got)
    begin
        e_st = exp_st.pop_front();
        chk_st(e_st, host.rd_q);
        chk_st(e_st, {status[7:1], busy});
    end

    // second variant's engine: done one cycle after each start
    always @(posedge i_clock)
    begin
        done64 <= (op64 === 1'b1);
        if (op64 === 1'b1)
            chk_op(exp_op64.size() ? exp_op64.pop_front() : 26'h3ffffff,
                {kind64, addr64});
    end

    // array engine stand-in: checks each start, answers four cycles later
    always @(posedge i_clock)
    begin
        i_op_done <= 1'b0;
        if (op_start === 1'b1)
        begin
            chk_op(exp_op.size() ? exp_op.pop_front() : 26'h3ffffff,
                {op_kind, op_addr});
            repeat (3) @(posedge i_clock);
            i_op_done <= 1'b1;
        end
    end

    always @(posedge i_clock)
    begin
        cyc++;
        if (cyc == 80000)
        begin
            mismatches++;
            finish_test();
        end
    end

    initial
    begin
        repeat (12) @(posedge i_clock);
        i_rst_n <= 1'b1;
        repeat (3) @(posedge i_clock);
        rd(8'h00);
        op(`OPC_WRITE_ENABLE, 8'h00);
        rd(8'h02);
        op(`OPC_WRITE_DISABLE, 8'h00);
        rd(8'h00);
        op(`OPC_STATUS_WRITE, 8'h1c);
        rd(8'h00);
        op(`OPC_WRITE_ENABLE, 8'h00);
        host.frame({`OPC_STATUS_WRITE, 8'h1c, 24'h0}, 15);
        rd(8'h02);
        op(`OPC_WRITE_DISABLE, 8'h00);
        $display("test latch done");
        for (int c = 0; c < 8; c++)
        begin
            op(`OPC_WRITE_ENABLE, 8'h00);
            op(`OPC_STATUS_WRITE, {3'h0, c[2:0], 2'h0});
            poll();
            rd({3'h0, c[2:0], 2'h0});
            b = c ? 25'h1000000 - (25'h0040000 << (c - 1)) : 25'h1000000;
            r = xorshift();
            attempt(`OPC_PAGE_PROGRAM, b[23:0], 40, 4'(c),
                !prot(c[2:0], b[23:0]));
            attempt(`OPC_SECTOR_ERASE, b[23:0] - 24'h1, 32, 4'(c),
                !prot(c[2:0], b[23:0] - 24'h1));
            attempt(`OPC_PAGE_PROGRAM, r[31:8], 40, 4'(c),
                !prot(c[2:0], r[31:8]));
            attempt(`OPC_BULK_ERASE, 24'h0, 8, 4'(c), c == 0);
        end
        op(`OPC_WRITE_ENABLE, 8'h00);
        op(`OPC_STATUS_WRITE, 8'h20);
        poll();
        rd(8'h00);
        chk_st(8'h20, st64);
        r = xorshift();
        attempt(`OPC_PAGE_PROGRAM, r[31:8], 40, 4'h8, 1'b1);
        $display("test regions done");
        op(`OPC_WRITE_ENABLE, 8'h00);
        op(`OPC_STATUS_WRITE, 8'h8c);
        poll();
        rd(8'h8c);
        @(posedge i_clock);
        i_write_protect_n <= 1'b0;
        op(`OPC_WRITE_ENABLE, 8'h00);
        op(`OPC_STATUS_WRITE, 8'h00);
        rd(8'h8e);
        @(posedge i_clock);
        i_write_protect_n <= 1'b1;
        op(`OPC_STATUS_WRITE, 8'h00);
        poll();
        rd(8'h00);
        $display("test protect pin done");
        chk_op(26'h0, 26'(exp_op.size() + exp_op64.size()));
        finish_test();
    end
endmodule
